// >>> dv/bsc_link_sva.sv
// Assertions on the link between the configuring end and the device.
`timescale 1ns/1ps
module bsc_link_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Configuration
  input wire logic        gain_we,
  input wire logic [31:0] gain_ext,
  // Results
  input wire logic [23:0] speed,
  input wire logic        speed_valid,
  input wire logic [23:0] gain_int,
  input wire logic        gain_wide
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Gain conversion
  a_gain_narrow: assert property (
    gain_we && (&gain_ext[31:23] || ~|gain_ext[31:23])
    |=> gain_int == $past(gain_ext[23:0]) && !gain_wide)
    else $error("Narrow gain form is wrong.");
  a_gain_wide: assert property (
    gain_we && !(&gain_ext[31:23] || ~|gain_ext[31:23])
    |=> gain_int == $past(gain_ext[31:8]) && gain_wide)
    else $error("Wide gain form is wrong.");
  a_gain_hold: assert property (!gain_we |=> $stable({gain_int, gain_wide}))
    else $error("Gain changed without a write.");
  a_gain_sign: assert property (gain_we |=> gain_int[23] == $past(gain_ext[31]))
    else $error("Gain lost its sign.");

  // ==========================================================================
  // Speed results
  a_valid_pulse: assert property (speed_valid |=> !speed_valid [*8])
    else $error("Speed results came too close.");
  a_speed_cause: assert property ($changed(speed) |-> speed_valid)
    else $error("Speed changed without a result.");
  a_speed_range: assert property (speed_valid |-> !speed[23])
    else $error("Speed above the largest fraction.");
  a_speed_stands: assert property (speed_valid |=> $stable(speed) [*8])
    else $error("Speed did not stand.");
endmodule // bsc_link_sva

// >>> dv/tb_bldc_speed_and_commutation.sv
// Self-checking bench for both ends of the speed and commutation block.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("Error at %0t ns: got %h, expected %h", $time, (a), (e)); end end
module tb_bldc_speed_and_commutation;
  logic                          clk = 1'b0;
  logic                          sys_rst = 1'b1;
  logic                          wr_valid = 1'b0;
  bsc_pkg::bsc_wr_type           wr_sel = bsc_pkg::WR_GAIN;
  logic [4:0]                    wr_addr = 5'h00;
  logic [31:0]                   wr_data = 32'h00000000;
  logic                          wr_ready;
  logic [23:0]                   speed;
  logic                          speed_fresh;
  logic [23:0]                   gain_int;
  logic                          gain_wide;
  logic                          hall_edge = 1'b0;
  logic [1:0]                    hall_phase = 2'h0;
  logic                          hall_rise = 1'b0;
  logic                          dir_dec = 1'b0;
  // Tick every cycle, so a sector period equals the Hall spacing in cycles;
  // only the stall test stops it.
  logic                          tick = 1'b1;
  bsc_pkg::bsc_chst_type [2:0]   base_state;
  bsc_pkg::bsc_chst_type [2:0]   comp_state;
  logic [2:0]                    duty_negate;
  logic [2:0]                    duty_negate_next;
  logic [23:0]                   sector_period;
  logic [26:0]                   rev_period;
  int                            bad_count = 0;
  int                            total_checks = 0;

  bsc_link_if lnk ();
  bsc_host i_bsc_host (.clk, .sys_rst, .wr_valid, .wr_sel, .wr_addr, .wr_data, .wr_ready,
                       .speed, .speed_fresh, .gain_int, .gain_wide, .lnk(lnk));
  bsc_dev i_bsc_dev (.clk, .sys_rst, .lnk(lnk), .hall_edge, .hall_phase, .hall_rise,
                     .dir_dec, .tick, .base_state, .comp_state, .duty_negate,
                     .duty_negate_next, .sector_period, .rev_period);
  bsc_link_sva i_bsc_link_sva (.clk, .sys_rst, .gain_we(lnk.gain_we),
                               .gain_ext(lnk.gain_ext), .speed(lnk.speed),
                               .speed_valid(lnk.speed_valid), .gain_int(lnk.gain_int),
                               .gain_wide(lnk.gain_wide));

  initial begin
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Drivers
  // Writes are held high across back-to-back calls; idle drops the request.
  task automatic wr(input bsc_pkg::bsc_wr_type s, input logic [4:0] a, input logic [31:0] d);
    wr_valid = 1'b1;
    wr_sel = s;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
  endtask

  task automatic idle();
    wr_valid = 1'b0;
    @(negedge clk);
  endtask

  // Returns after the off command has landed, before the on command.
  task automatic pulse(input logic [1:0] ph, input logic r, input logic d);
    hall_phase = ph;
    hall_rise = r;
    dir_dec = d;
    hall_edge = 1'b1;
    @(negedge clk);
    hall_edge = 1'b0;
    @(negedge clk);
  endtask

  // One Hall edge every 40 cycles, so each division finishes before the next.
  task automatic hall_step(input int n, input logic chk, input logic [23:0] exp);
    int seen;
    seen = 0;
    pulse(2'(n % 3), n[0], 1'b0);
    if (chk) `CHK(sector_period, 24'h000028)
    for (int i = 0; i < 38; i++) begin
      if (speed_fresh === 1'b1) begin
        seen++;
        if (chk) `CHK(speed, exp)
      end
      @(negedge clk);
    end
    if (chk) `CHK(seen, 1)
  endtask

  // ==========================================================================
  // Tests
  task automatic test_gain();
    logic [31:0] g [4] = '{32'h00400000, 32'hFF800000, 32'h02800000, 32'hFE000000};
    logic [24:0] e [4] = '{25'h0400000, 25'h0800000, 25'h1028000, 25'h1FE0000};
    for (int i = 0; i < 4; i++) begin
      wr(bsc_pkg::WR_GAIN, 5'h00, g[i]);
      idle();
      @(negedge clk);
      `CHK({gain_wide, gain_int}, e[i])
    end
    `CHK(wr_ready, 1'b1)
    $display("Gain conversion test done");
  endtask

  task automatic test_comm();
    wr(bsc_pkg::WR_TABLE, 5'h02, 32'h01020301);
    wr(bsc_pkg::WR_TABLE, 5'h03, 32'h01010000);
    wr(bsc_pkg::WR_TABLE, 5'h14, 32'h01030200);
    wr(bsc_pkg::WR_TABLE, 5'h15, 32'h00000102);
    idle();
    pulse(2'h0, 1'b1, 1'b0);
    `CHK(base_state[1], bsc_pkg::ST_OFF_HIGH)
    `CHK(base_state[0], bsc_pkg::ST_OFF_LOW)
    @(negedge clk);
    `CHK(base_state[0], bsc_pkg::ST_ON_HIGH)
    `CHK(comp_state[0], bsc_pkg::ST_ON_LOW)
    `CHK(comp_state[1], bsc_pkg::ST_OFF_LOW)
    `CHK({duty_negate[1:0], duty_negate_next[1]}, 3'h3)
    repeat (37) @(negedge clk);
    pulse(2'h1, 1'b0, 1'b1);
    `CHK(comp_state[0], bsc_pkg::ST_OFF_HIGH)
    `CHK(base_state[2], bsc_pkg::ST_OFF_LOW)
    @(negedge clk);
    `CHK(base_state[2], bsc_pkg::ST_ON_LOW)
    `CHK(comp_state[2], bsc_pkg::ST_ON_HIGH)
    `CHK({duty_negate[2], duty_negate[0], duty_negate_next[0]}, 3'h3)
    repeat (37) @(negedge clk);
    $display("Commutation test done");
  endtask

  task automatic test_speed();
    wr(bsc_pkg::WR_SCALE, 5'h00, 32'h0000F000);
    wr(bsc_pkg::WR_CFG, 5'h00, 32'h00000000);
    idle();
    for (int n = 0; n < 7; n++) hall_step(n, 1'b0, 24'h000000);
    hall_step(7, 1'b1, 24'h000100);
    `CHK(rev_period, 27'h00000F0)
    wr(bsc_pkg::WR_CFG, 5'h00, 32'h00000001);
    idle();
    hall_step(0, 1'b0, 24'h000000);
    hall_step(1, 1'b1, 24'h000600);
    wr(bsc_pkg::WR_SCALE, 5'h00, 32'hFFFFFFFF);
    idle();
    hall_step(2, 1'b0, 24'h000000);
    hall_step(3, 1'b1, 24'h7FFFFF);
    $display("Speed test done");
  endtask

  // A stalled timebase gives a zero sector, and the speed must saturate.
  task automatic test_tick();
    wr(bsc_pkg::WR_SCALE, 5'h00, 32'h00000001);
    idle();
    tick = 1'b0;
    hall_step(4, 1'b0, 24'h000000);
    pulse(2'h2, 1'b0, 1'b0);
    `CHK(sector_period, 24'h000000)
    repeat (33) @(negedge clk);
    `CHK({speed_fresh, speed}, 25'h17FFFFF)
    tick = 1'b1;
    $display("Stalled timebase test done");
  endtask

  task automatic final_report();
    $display("Checks: %0d, mismatches: %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    test_gain();
    test_comm();
    test_speed();
    test_tick();
    final_report();
  end

  // The tests need about 670 cycles; eight times that means a hang.
  initial begin
    #22000;
    bad_count++;
    final_report();
  end
endmodule // tb_bldc_speed_and_commutation

// >>> rtl/bsc_dev.sv
// Device end: gain conversion, period measurement, speed and commutation.
`timescale 1ns/1ps
module bsc_dev #(
  parameter int PW  = 24,
  parameter int NPH = 3
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Configuration link
  bsc_link_if.dev                     lnk,
  // Hall edge decoder and timebase
  input  wire logic                   hall_edge,
  input  wire logic [1:0]             hall_phase,
  input  wire logic                   hall_rise,
  input  wire logic                   dir_dec,
  input  wire logic                   tick,
  // PWM phase channels
  output bsc_pkg::bsc_chst_type [NPH-1:0] base_state,
  output bsc_pkg::bsc_chst_type [NPH-1:0] comp_state,
  output logic [NPH-1:0]              duty_negate,
  output logic [NPH-1:0]              duty_negate_next,
  // Measurements
  output logic [PW-1:0]               sector_period,
  output logic [PW+2:0]               rev_period
);

  localparam int RW = PW + 3;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [23:0]                        gain_int;
    logic                               gain_wide;
    logic [31:0]                        scale;
    logic                               use_sector;
    logic [bsc_pkg::TBL_N-1:0][31:0]    tbl;
    logic [PW-1:0]                      tick_cnt;
    logic [bsc_pkg::SECTORS-1:0][PW-1:0] hist;
    logic [PW-1:0]                      sector;
    logic [RW-1:0]                      rev;
    logic                               div_go;
    logic [3:0]                         cmd_base;
    bsc_pkg::bsc_seq_type               seq;
    bsc_pkg::bsc_chst_type [NPH-1:0]    bst;
    bsc_pkg::bsc_chst_type [NPH-1:0]    cst;
    logic [NPH-1:0]                     neg;
    logic [NPH-1:0]                     pend;
  } bsc_dev_st_type;

  bsc_dev_st_type        s_q;
  bsc_dev_st_type        s_d;
  logic [31:0]           cmd;
  logic [7:0]            ch;
  bsc_pkg::bsc_chst_type cmd_bst;
  bsc_pkg::bsc_chst_type cmd_cst;
  logic                  cmd_off;
  logic                  cmd_neg;
  logic [RW-1:0]         divisor;
  logic                  div_done;
  logic [23:0]           div_quot;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.div_go = 1'b0;
    cmd = '0;

    // ========================================================================
    // Gain conversion: values that fit in one sign bit keep full fraction
    // resolution, larger ones drop eight fraction bits to keep the range.
    if (lnk.gain_we) begin
      if (lnk.gain_ext[31:bsc_pkg::GAIN_FRAC_LSB] == '0 ||
          lnk.gain_ext[31:bsc_pkg::GAIN_FRAC_LSB] == '1) begin
        s_d.gain_int  = lnk.gain_ext[23:0]; // RQ5
        s_d.gain_wide = 1'b0;
      end else begin
        s_d.gain_int  = lnk.gain_ext[31:bsc_pkg::GAIN_WIDE_LSB]; // RQ5
        s_d.gain_wide = 1'b1;
      end
    end
    if (lnk.scale_we) begin
      s_d.scale = lnk.scale;
    end
    if (lnk.cfg_we) begin
      s_d.use_sector = lnk.sector_sel; // RQ6
    end
    if (lnk.tbl_we) begin
      s_d.tbl[lnk.tbl_addr] = lnk.tbl_data; // RQ12
    end

    // ========================================================================
    // Tick counter holds at its top value for a stalled rotor.
    if (tick && s_q.tick_cnt != '1) begin
      s_d.tick_cnt = s_q.tick_cnt + PW'(1); // RQ3
    end

    // ========================================================================
    // Commutation sequence: off command first, on command next cycle.
    case (s_q.seq)
      bsc_pkg::SEQ_OFF: begin
        cmd    = s_q.tbl[{s_q.cmd_base, 1'b0}]; // RQ11
        s_d.seq = bsc_pkg::SEQ_ON;
      end
      bsc_pkg::SEQ_ON: begin
        cmd    = s_q.tbl[{s_q.cmd_base, 1'b1}]; // RQ11
        s_d.seq = bsc_pkg::SEQ_IDLE;
      end
      default: begin
        cmd    = '0;
        s_d.seq = bsc_pkg::SEQ_IDLE;
      end
    endcase

    // ========================================================================
    // Command decode: the idle word is never applied, so an empty table slot
    // only matters while a sequence is running.
    ch      = cmd[bsc_pkg::CMD_CH_LSB +: 8]; // RQ18
    cmd_bst = bsc_pkg::bsc_chst_type'(cmd[bsc_pkg::CMD_BASE_LSB +: 2]); // RQ14
    cmd_cst = bsc_pkg::bsc_chst_type'(cmd[bsc_pkg::CMD_COMP_LSB +: 2]); // RQ14
    cmd_neg = (cmd[bsc_pkg::CMD_OPT_LSB +: 8] == bsc_pkg::OPT_DUTY_NEGATE); // RQ15
    // Both off states have the upper state bit set.
    cmd_off = cmd[bsc_pkg::CMD_BASE_LSB + 1]; // RQ14

    // A channel byte beyond the last phase is ignored rather than wrapped.
    if (s_q.seq != bsc_pkg::SEQ_IDLE && ch < 8'(NPH)) begin // RQ13
      s_d.bst[ch[1:0]] = cmd_bst;
      s_d.cst[ch[1:0]] = cmd_cst;
      if (cmd_off) begin
        // A phase going off keeps its option for the next switch-on.
        s_d.pend[ch[1:0]] = cmd_neg; // RQ16
      end else begin
        s_d.neg[ch[1:0]] = cmd_neg; // RQ15
      end
    end

    // ========================================================================
    // Hall edge: close the sector and slide the six-sector window.
    // A new edge in the off step restarts the sequence; the older off command
    // still lands, its on command is lost. The window starts from zeros, so the
    // first five revolution periods after reset read short.
    if (hall_edge) begin
      s_d.sector   = s_q.tick_cnt; // RQ7
      s_d.tick_cnt = tick ? PW'(1) : '0;
      s_d.hist     = {s_q.hist[bsc_pkg::SECTORS-2:0], s_q.tick_cnt}; // RQ7
      s_d.rev      = RW'(s_q.rev + RW'(s_q.tick_cnt)
                         - RW'(s_q.hist[bsc_pkg::SECTORS-1])); // RQ8
      s_d.cmd_base = {dir_dec, hall_phase, hall_rise}; // RQ17
      s_d.seq      = bsc_pkg::SEQ_OFF; // RQ11
      s_d.div_go   = 1'b1;
    end

    if (sys_rst) begin
      s_d = s_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q            <= '0;
      s_q.gain_int   <= bsc_pkg::GAIN_RST;
      s_q.scale      <= bsc_pkg::SCALE_RST;
      s_q.seq        <= bsc_pkg::SEQ_IDLE;
      // Phases leave reset switched off with both pins low.
      s_q.bst        <= '{default: bsc_pkg::ST_OFF_LOW};
      s_q.cst        <= '{default: bsc_pkg::ST_OFF_LOW};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Speed: scaling constant over the chosen period, one edge after the
  // period update so the new value is used.
  assign divisor = s_q.use_sector ? RW'(s_q.sector) : s_q.rev; // RQ6

  bsc_div #(
    .NW (bsc_pkg::SCALE_W),
    .DW (RW)
  ) i_bsc_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (s_q.div_go),
    .dividend (s_q.scale),
    .divisor  (divisor),
    .done     (div_done),
    .quot     (div_quot)
  ); // RQ9

  // ==========================================================================
  // Outputs
  assign lnk.speed       = div_quot; // RQ1
  assign lnk.speed_valid = div_done;
  assign lnk.gain_int    = s_q.gain_int;
  assign lnk.gain_wide   = s_q.gain_wide;

  // One set of channel outputs per phase; the PWM side reads the option
  // of a phase only while that phase is switched on.
  for (genvar p = 0; p < NPH; p++) begin : g_phase
    assign base_state[p]       = s_q.bst[p];
    assign comp_state[p]       = s_q.cst[p];
    assign duty_negate[p]      = s_q.neg[p];
    assign duty_negate_next[p] = s_q.pend[p];
  end
  assign sector_period    = s_q.sector;
  assign rev_period       = s_q.rev;

endmodule // bsc_dev

// >>> rtl/bsc_div.sv
// Sequential divider for speed, saturating to the largest fraction.
`timescale 1ns/1ps
module bsc_div #(
  parameter int NW = 32,
  parameter int DW = 27
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // Request
  input  wire logic          start,
  input  wire logic [NW-1:0] dividend,
  input  wire logic [DW-1:0] divisor,
  // Result
  output logic               done,
  output logic [23:0]        quot
);

  typedef struct packed {
    logic          busy;
    logic [5:0]    cnt;
    logic [DW-1:0] rem;
    logic [NW-1:0] q;
    logic [DW-1:0] dv;
    logic          done;
    logic [23:0]   res;
  } bsc_div_st_type;

  bsc_div_st_type s_q;
  bsc_div_st_type s_d;
  logic [DW:0]    r;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    r = {s_q.rem, s_q.q[NW-1]};
    if (start) begin
      // A new request restarts any division still running.
      s_d.busy = 1'b1;
      s_d.cnt  = 6'(NW);
      s_d.rem  = '0;
      s_d.q    = dividend;
      s_d.dv   = divisor;
    end else if (s_q.busy) begin
      s_d.q = {s_q.q[NW-2:0], (r >= {1'b0, s_q.dv})};
      if (r >= {1'b0, s_q.dv}) begin
        s_d.rem = DW'(r - {1'b0, s_q.dv});
      end else begin
        s_d.rem = r[DW-1:0];
      end
      s_d.cnt = s_q.cnt - 6'h01;
      if (s_q.cnt == 6'h01) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        if (s_q.dv == '0 || s_d.q[NW-1:23] != '0) begin // RQ2
          s_d.res = bsc_pkg::FRAC_MAX; // RQ19
        end else begin
          s_d.res = s_d.q[23:0]; // RQ9
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign quot = s_q.res;

endmodule // bsc_div

// >>> rtl/bsc_host.sv
// Configuring end: turns software writes into link strobes, keeps results.
`timescale 1ns/1ps
module bsc_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Software write request
  input  wire logic        wr_valid,
  input  bsc_pkg::bsc_wr_type wr_sel,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  output logic             wr_ready,
  // Results to software
  output logic [23:0]      speed,
  output logic             speed_fresh,
  output logic [23:0]      gain_int,
  output logic             gain_wide,
  // Link
  bsc_link_if.host         lnk
);

  typedef struct packed {
    logic        gain_we;
    logic        scale_we;
    logic        cfg_we;
    logic        tbl_we;
    logic [4:0]  addr;
    logic [31:0] data;
    logic [23:0] speed;
    logic        fresh;
  } bsc_host_st_type;

  bsc_host_st_type s_q;
  bsc_host_st_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.gain_we  = wr_valid && wr_sel == bsc_pkg::WR_GAIN; // RQ4
    s_d.scale_we = wr_valid && wr_sel == bsc_pkg::WR_SCALE; // RQ10
    s_d.cfg_we   = wr_valid && wr_sel == bsc_pkg::WR_CFG;
    s_d.tbl_we   = wr_valid && wr_sel == bsc_pkg::WR_TABLE; // RQ12
    if (wr_valid) begin
      s_d.addr = wr_addr;
      s_d.data = wr_data; // RQ13
    end
    s_d.fresh = lnk.speed_valid;
    if (lnk.speed_valid) begin
      s_d.speed = lnk.speed;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wr_ready       = 1'b1;
  assign lnk.gain_we    = s_q.gain_we;
  assign lnk.gain_ext   = s_q.data;
  assign lnk.scale_we   = s_q.scale_we;
  assign lnk.scale      = s_q.data;
  assign lnk.cfg_we     = s_q.cfg_we;
  assign lnk.sector_sel = s_q.data[0];
  assign lnk.tbl_we     = s_q.tbl_we;
  assign lnk.tbl_addr   = s_q.addr;
  assign lnk.tbl_data   = s_q.data;
  assign speed          = s_q.speed;
  assign speed_fresh    = s_q.fresh;
  assign gain_int       = lnk.gain_int;
  assign gain_wide      = lnk.gain_wide;

endmodule // bsc_host

// >>> rtl/bsc_link_if.sv
// Link between the configuring party and the speed and commutation device.
`timescale 1ns/1ps
interface bsc_link_if;
  // Configuration writes, one-cycle strobes.
  logic        gain_we;
  logic [31:0] gain_ext;
  logic        scale_we;
  logic [31:0] scale;
  logic        cfg_we;
  logic        sector_sel;
  logic        tbl_we;
  logic [4:0]  tbl_addr;
  logic [31:0] tbl_data;
  // Results back from the device.
  logic [23:0] speed;
  logic        speed_valid;
  logic [23:0] gain_int;
  logic        gain_wide;

  modport dev (
    input  gain_we, gain_ext, scale_we, scale, cfg_we, sector_sel,
    input  tbl_we, tbl_addr, tbl_data,
    output speed, speed_valid, gain_int, gain_wide
  );
  modport host (
    output gain_we, gain_ext, scale_we, scale, cfg_we, sector_sel,
    output tbl_we, tbl_addr, tbl_data,
    input  speed, speed_valid, gain_int, gain_wide
  );
endinterface : bsc_link_if

// >>> rtl/bsc_pkg.sv
// Constants and types shared by both ends of the speed and commutation block.
// ============================================================================
// What this block does
// RQ1 - Non-time quantities are 24-bit signed 1.23 fractions.
// RQ2 - Minus one is 0x800000, maximum is 0x7FFFFF.
// RQ3 - Periods are kept as raw timer tick counts.
// RQ4 - Software gives gains as 32-bit 9.23 fractions.
// RQ5 - Gain becomes 9.15 or 1.23 by magnitude.
// RQ6 - Speed uses revolution period; option selects sector.
// RQ7 - Sector spans two Hall edges; six make revolution.
// RQ8 - Revolution period refreshed on every Hall edge.
// RQ9 - Speed equals scaling constant divided by period.
// RQ10 - Software precomputes the scaling constant.
// RQ11 - Each Hall edge applies off command, then on.
// RQ12 - Software supplies command pairs per edge and direction.
// RQ13 - Command word holds channel, two states, options.
// RQ14 - States: on high, on low, off low, off high.
// RQ15 - Option keeps or negates the signed duty.
// RQ16 - On-option immediate; off-option waits for next on.
// RQ17 - Decrement tables follow the timing in reverse.
// RQ18 - Options top byte, then complementary, base, channel.
// RQ19 - Overflow or zero period saturates speed to maximum.
package bsc_pkg;

  // ==========================================================================
  // Fractional format
  localparam int          FRAC_W   = 24;
  localparam logic [23:0] FRAC_MIN = 24'h800000;
  localparam logic [23:0] FRAC_MAX = 24'h7FFFFF;
  localparam int          GAIN_W   = 32;
  localparam int          GAIN_FRAC_LSB = 23;
  localparam int          GAIN_WIDE_LSB = 8;
  localparam logic [23:0] GAIN_RST = 24'h000000;

  // ==========================================================================
  // Periods and speed
  localparam int          PER_W     = 24;
  localparam int          SCALE_W   = 32;
  localparam int          SECTORS   = 6;
  localparam logic [31:0] SCALE_RST = 32'h00000000;

  // ==========================================================================
  // Commutation command word
  localparam int          CMD_W        = 32;
  localparam int          CMD_CH_LSB   = 0;
  localparam int          CMD_BASE_LSB = 8;
  localparam int          CMD_COMP_LSB = 16;
  localparam int          CMD_OPT_LSB  = 24;
  localparam int          TBL_AW       = 5;
  localparam int          TBL_N        = 32;
  localparam logic [7:0]  OPT_DUTY_KEEP   = 8'h00;
  localparam logic [7:0]  OPT_DUTY_NEGATE = 8'h01;

  typedef enum logic [1:0] {
    ST_ON_HIGH,
    ST_ON_LOW,
    ST_OFF_LOW,
    ST_OFF_HIGH
  } bsc_chst_type;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_OFF,
    SEQ_ON
  } bsc_seq_type;

  typedef enum logic [1:0] {
    WR_GAIN,
    WR_SCALE,
    WR_CFG,
    WR_TABLE
  } bsc_wr_type;

endpackage : bsc_pkg
